/* File: serial_boot_pkg.sv */
// constants and types for the serial boot ram transfer engine
package serial_boot_pkg;

    // ****************************************
    // protocol codes
    // ****************************************
    localparam logic [7:0] MODE_UART_CODE = 8'h86;
    localparam logic [7:0] MODE_CLKD_CODE = 8'h30;
    localparam logic [7:0] CMD_RAM_LOAD   = 8'h10;
    localparam logic [7:0] ANS_NAK        = 8'h11;
    localparam logic [7:0] ANS_COMM_ERR   = 8'h18;
    localparam logic [31:0] RAM_LOAD_BASE = 32'h2000_0400;

    // ****************************************
    // sizes, counts and reset values
    // ****************************************
    localparam int          PWD_BYTES       = 12;
    localparam logic [3:0]  PWD_LAST_IDX    = 4'hb;
    localparam logic [3:0]  HDR_LAST_IDX    = 4'h5;
    localparam logic [3:0]  UART_START_BIT  = 4'h0;
    localparam logic [3:0]  UART_MODE_ENTRY = 4'h2;
    localparam logic [3:0]  UART_STOP_BIT   = 4'h9;
    localparam logic [3:0]  UART_TX_BITS    = 4'ha;
    localparam logic [3:0]  CLKD_LAST_BIT   = 4'h7;
    localparam logic [15:0] BAUD_MIN_CYCLES = 16'h0004;
    localparam int          FIFO_WIDTH      = 8;
    localparam int          FIFO_DEPTH      = 32;
    localparam logic        LINE_IDLE       = 1'b1;

    // ****************************************
    // protocol states
    // ****************************************
    typedef enum logic [3:0] {
        S_MODE  = 4'h0,
        S_CMD   = 4'h1,
        S_PWD   = 4'h2,
        S_PSUM  = 4'h3,
        S_HDR   = 4'h4,
        S_HSUM  = 4'h5,
        S_DATA  = 4'h6,
        S_DSUM  = 4'h7,
        S_SEND  = 4'h8,
        S_DRAIN = 4'h9,
        S_DONE  = 4'ha,
        S_ABORT = 4'hb
    } boot_state_t;

endpackage

/* File: byte_stream_if.sv */
// valid/ready stream carrier between the engine and its fifo
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
    logic         in_valid;   // producer offers a word
    logic         in_ready;   // fifo has room
    logic [W-1:0] in_data;    // offered word
    logic         out_valid;  // fifo holds a word
    logic         out_ready;  // consumer takes it
    logic [W-1:0] out_data;   // oldest word

    modport engine (output in_valid, in_data, out_ready,
                    input  in_ready, out_valid, out_data);
    modport store  (input  in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* File: byte_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic    clk_in,
    input  wire logic    rstn_in,
    // stream
    byte_stream_if.store bus
);
    localparam int AW = $clog2(DEPTH);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;  // storage words
        logic [AW:0]             wp;   // write pointer with wrap bit
        logic [AW:0]             rp;   // read pointer with wrap bit
    } fifo_t;

    fifo_t r;       // registered state
    fifo_t next_r;  // next state
    logic  full;    // wrap bits differ, index equal
    logic  empty;   // pointers equal

    assign full          = (r.wp[AW] != r.rp[AW]) &&
                           (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign empty         = (r.wp == r.rp);
    assign bus.in_ready  = ~full;
    assign bus.out_valid = ~empty;
    assign bus.out_data  = r.mem[r.rp[AW-1:0]];

    // push and pop may happen in the same cycle
    always_comb
    begin
        next_r = r;
        if (bus.in_valid && !full)
        begin
            next_r.mem[r.wp[AW-1:0]] = bus.in_data;
            next_r.wp                = r.wp + 1'b1;
        end
        if (bus.out_ready && !empty)
        begin
            next_r.rp = r.rp + 1'b1;
        end
    end

    // register the state
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            r <= '0;
        else
            r <= next_r;
    end
endmodule
`default_nettype wire

/* File: serial_boot_ram_loader.sv */
// serial boot engine for the ram transfer command
`timescale 1ns/1ps
`default_nettype none
module serial_boot_ram_loader (
    // clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RSTN_IN,
    // serial link pins
    input  wire logic        RXD_IN,
    input  wire logic        SERIAL_SHIFT_CLOCK_IN,
    output logic             TXD_OUT,
    output logic             HANDSHAKE_OUT_LINE_OUT,
    // stored password, byte 0 in bits 7:0
    input  wire logic [95:0] PASSWORD_IN,
    // ram write port
    input  wire logic        RAM_READY_IN,
    output logic             RAM_WE_OUT,
    output logic [31:0]      RAM_ADDR_OUT,
    output logic [7:0]       RAM_DATA_OUT,
    // session result
    output logic             JUMP_OUT,
    output logic [31:0]      JUMP_ADDR_OUT,
    output logic             ABORT_OUT
);
    import serial_boot_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        boot_state_t st;        // protocol position
        boot_state_t ret;       // state after the answer is out
        logic        clk_mode;  // clocked interface chosen
        logic [3:0]  idx;       // byte index inside a stage
        logic [7:0]  sum;       // running byte sum
        logic        pwd_ok;    // all password bytes matched
        logic [47:0] hdr;       // address and count shift
        logic [15:0] remain;    // payload bytes still due
        logic        err;       // communication error seen
        logic        rx_s1;     // rx sync stage one
        logic        rx_s2;     // rx sync stage two
        logic        rx_q;      // rx delayed for edges
        logic        ck_s1;     // shift clock sync one
        logic        ck_s2;     // shift clock sync two
        logic        ck_q;      // shift clock delayed
        logic        measuring; // timing the mode byte low
        logic [16:0] meas;      // low time of two bits
        logic [15:0] period;    // cycles per uart bit
        logic        u_act;     // uart receiver busy
        logic [3:0]  u_bit;     // uart receive bit slot
        logic [15:0] u_cnt;     // uart sample countdown
        logic [7:0]  u_sh;      // uart receive shift
        logic [3:0]  c_bit;     // clocked bit count
        logic [7:0]  c_sh;      // clocked receive shift
        logic [7:0]  c_tx;      // clocked transmit shift
        logic        tx_busy;   // answer being sent
        logic [9:0]  tx_sh;     // uart transmit frame
        logic [3:0]  t_bit;     // uart transmit slot
        logic [15:0] t_cnt;     // uart bit countdown
        logic        txd;       // transmit pin level
        logic        push;      // fifo write strobe
        logic [7:0]  push_data; // fifo write word
        logic        ram_we;    // ram write pending
        logic [31:0] ram_addr;  // ram write address
        logic [7:0]  ram_data;  // ram write data
        logic [31:0] drain_addr;// next ram address
        logic        jump;      // jump pulse
        logic        abort;     // session abandoned
        logic        hs;        // handshake level
    } eng_t;

    eng_t        r;        // registered state
    eng_t        next_r;   // next state
    logic        got;      // a byte arrived this cycle
    logic [7:0]  gb;       // the byte
    logic        ge;       // its framing was bad
    logic        ack_go;   // load an answer
    logic [7:0]  ack_val;  // answer byte
    boot_state_t ack_ret;  // where to go after it
    logic [7:0]  tot;      // sum including checksum
    logic        bad;      // checksum wrong, sum not zero
    logic        rx_fall;  // rx line fell
    logic        rx_rise;  // rx line rose
    logic        ck_fall;  // shift clock fell
    logic        ck_rise;  // shift clock rose

    byte_stream_if #(.W(FIFO_WIDTH)) fq ();

    // payload buffer; its fullness holds the handshake low
    byte_fifo #(.W(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in  (SYS_CLK_IN),
        .rstn_in (RSTN_IN),
        .bus     (fq.store)
    );

    assign fq.in_valid  = r.push;
    assign fq.in_data   = r.push_data;
    assign fq.out_ready = ~r.ram_we | RAM_READY_IN;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_r  = r;
        got     = 1'b0;
        gb      = 8'h00;
        ge      = 1'b0;
        ack_go  = 1'b0;
        ack_val = 8'h00;
        ack_ret = S_CMD;
        tot     = r.sum + gb;
        bad     = 1'b0;
        // two flops ahead of any reader of the pins
        next_r.rx_s1 = RXD_IN;
        next_r.rx_s2 = r.rx_s1;
        next_r.rx_q  = r.rx_s2;
        next_r.ck_s1 = SERIAL_SHIFT_CLOCK_IN;
        next_r.ck_s2 = r.ck_s1;
        next_r.ck_q  = r.ck_s2;
        rx_fall = r.rx_q & ~r.rx_s2;
        rx_rise = ~r.rx_q & r.rx_s2;
        ck_fall = r.ck_q & ~r.ck_s2;
        ck_rise = ~r.ck_q & r.ck_s2;
        next_r.push = 1'b0;
        next_r.jump = 1'b0;

        // any shift clock edge during the mode byte picks clocked mode
        if (r.st == S_MODE && (ck_fall || ck_rise))
        begin
            next_r.clk_mode  = 1'b1;
            next_r.measuring = 1'b0;
            next_r.u_act     = 1'b0;
        end
        // 86h holds the line low for start plus bit 0: two bit times
        if (r.st == S_MODE && !r.clk_mode && !r.u_act)
        begin
            if (!r.measuring && rx_fall)
            begin
                next_r.measuring = 1'b1;
                next_r.meas      = 17'h00001;
            end
            else if (r.measuring && rx_rise)
            begin
                next_r.measuring = 1'b0;
                next_r.period    = r.meas[16:1];
                next_r.u_act     = 1'b1;
                next_r.u_bit     = UART_MODE_ENTRY;
                next_r.u_sh      = 8'h00;
                next_r.u_cnt     = {1'b0, r.meas[16:2]};
            end
            else if (r.measuring && (&r.meas))
                next_r.st = S_ABORT;
            else if (r.measuring)
                next_r.meas = r.meas + 17'h00001;
        end

        // uart receiver, samples mid bit, lsb first
        if (!r.clk_mode && r.u_act)
        begin
            if (r.u_cnt != 16'h0000)
                next_r.u_cnt = r.u_cnt - 16'h0001;
            else
            begin
                next_r.u_cnt = r.period - 16'h0001;
                next_r.u_bit = r.u_bit + 4'h1;
                if (r.u_bit == UART_START_BIT)
                    next_r.u_act = ~r.rx_s2; // glitch, not a start
                else if (r.u_bit != UART_STOP_BIT)
                    next_r.u_sh = {r.rx_s2, r.u_sh[7:1]};
                else
                begin
                    next_r.u_act = 1'b0;
                    got          = 1'b1;
                    gb           = r.u_sh;
                    ge           = ~r.rx_s2;
                end
            end
        end
        else if (!r.clk_mode && r.st != S_MODE && rx_fall)
        begin
            next_r.u_act = 1'b1;
            next_r.u_bit = UART_START_BIT;
            next_r.u_cnt = {1'b0, r.period[15:1]};
        end

        // clocked interface: drive on fall, sample on rise
        if (r.clk_mode || r.st == S_MODE)
        begin
            if (ck_fall && r.tx_busy)
            begin
                next_r.txd  = r.c_tx[0];
                next_r.c_tx = {1'b1, r.c_tx[7:1]};
            end
            if (ck_rise)
            begin
                next_r.c_sh  = {r.rx_s2, r.c_sh[7:1]};
                next_r.c_bit = r.c_bit + 4'h1;
                if (r.c_bit == CLKD_LAST_BIT)
                begin
                    next_r.c_bit = 4'h0;
                    if (r.tx_busy)
                        next_r.tx_busy = 1'b0;
                    else
                    begin
                        got = 1'b1;
                        gb  = {r.rx_s2, r.c_sh[7:1]};
                    end
                end
            end
        end

        // uart transmitter, full stop bit before done
        if (!r.clk_mode && r.tx_busy)
        begin
            if (r.t_cnt != 16'h0000)
                next_r.t_cnt = r.t_cnt - 16'h0001;
            else if (r.t_bit == UART_TX_BITS)
                next_r.tx_busy = 1'b0;
            else
            begin
                next_r.txd   = r.tx_sh[0];
                next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
                next_r.t_bit = r.t_bit + 4'h1;
                next_r.t_cnt = r.period - 16'h0001;
            end
        end

        // clocked errors are never answered
        if (got && ge && !r.clk_mode)
            next_r.err = 1'b1;
        tot = r.sum + gb;
        bad = (tot != 8'h00);

        // protocol sequence
        case (r.st)
            S_MODE:
                if (got && r.clk_mode && gb == MODE_CLKD_CODE)
                begin
                    ack_go  = 1'b1;
                    ack_val = MODE_CLKD_CODE;
                end
                else if (got && !r.clk_mode && !ge &&
                         gb == MODE_UART_CODE &&
                         r.period >= BAUD_MIN_CYCLES)
                begin
                    ack_go  = 1'b1;
                    ack_val = MODE_UART_CODE;
                end
                else if (got)
                    next_r.st = S_ABORT;
            S_CMD:
                if (got)
                begin
                    ack_go = 1'b1;
                    if (next_r.err)
                        ack_val = ANS_COMM_ERR;
                    else if (gb != CMD_RAM_LOAD)
                        ack_val = ANS_NAK;
                    else
                    begin
                        ack_val = CMD_RAM_LOAD;
                        ack_ret = S_PWD;
                    end
                end
            S_PWD:
                if (got)
                begin
                    next_r.sum = tot;
                    next_r.idx = r.idx + 4'h1;
                    if (gb != PASSWORD_IN[8*r.idx +: 8])
                        next_r.pwd_ok = 1'b0;
                    if (r.idx == PWD_LAST_IDX)
                        next_r.st = S_PSUM;
                end
            S_HDR:
                if (got)
                begin
                    next_r.sum = tot;
                    next_r.idx = r.idx + 4'h1;
                    next_r.hdr = {r.hdr[39:0], gb};
                    if (r.idx == HDR_LAST_IDX)
                        next_r.st = S_HSUM;
                end
            S_DATA:
                if (got)
                begin
                    next_r.sum       = tot;
                    next_r.push      = 1'b1;
                    next_r.push_data = gb;
                    if (!fq.in_ready && !r.clk_mode)
                        next_r.err = 1'b1;
                    next_r.remain = r.remain - 16'h0001;
                    if (r.remain == 16'h0001)
                        next_r.st = S_DSUM;
                end
            S_PSUM, S_HSUM, S_DSUM:
                if (got)
                begin
                    ack_go = 1'b1;
                    if (next_r.err)
                        ack_val = ANS_COMM_ERR;
                    else if (bad || (r.st == S_PSUM && !r.pwd_ok))
                        ack_val = ANS_NAK;
                    else
                    begin
                        ack_val = CMD_RAM_LOAD;
                        if (r.st == S_PSUM)
                            ack_ret = S_HDR;
                        else if (r.st == S_DSUM)
                            ack_ret = S_DRAIN;
                        else if (r.hdr[15:0] == 16'h0000)
                            ack_ret = S_DSUM;
                        else
                            ack_ret = S_DATA;
                        if (r.st == S_HSUM)
                            next_r.drain_addr = r.hdr[47:16];
                        next_r.remain     = r.hdr[15:0];
                    end
                end
            S_SEND:
                if (!r.tx_busy)
                    next_r.st = r.ret;
            S_DRAIN:
                // jump only once every byte sits in ram
                if (!fq.out_valid && !r.ram_we && !r.push)
                begin
                    next_r.jump = 1'b1;
                    next_r.st   = S_DONE;
                end
            S_DONE, S_ABORT:
                next_r.st = r.st;
            default:
                next_r.st = S_ABORT;
        endcase

        // answer loader, each stage restarts its sum
        if (ack_go)
        begin
            next_r.st      = S_SEND;
            next_r.ret     = ack_ret;
            next_r.tx_busy = 1'b1;
            next_r.c_tx    = ack_val;
            next_r.tx_sh   = {1'b1, ack_val, 1'b0};
            next_r.t_bit   = 4'h0;
            next_r.t_cnt   = 16'h0000;
            next_r.sum     = 8'h00;
            next_r.idx     = 4'h0;
            next_r.err     = 1'b0;
            next_r.pwd_ok  = 1'b1;
        end

        // ram write port drains the fifo
        if (fq.out_valid && fq.out_ready)
        begin
            next_r.ram_we     = 1'b1;
            next_r.ram_data   = fq.out_data;
            next_r.ram_addr   = r.drain_addr;
            next_r.drain_addr = r.drain_addr + 32'h0000_0001;
        end
        else if (RAM_READY_IN)
            next_r.ram_we = 1'b0;

        next_r.abort = (next_r.st == S_ABORT);
        next_r.hs    = fq.in_ready && next_r.st != S_DRAIN &&
                       next_r.st != S_DONE && !next_r.abort;
    end

    // register the state; idle lines reset high
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            r        <= '0;
            r.st     <= S_MODE;
            r.pwd_ok <= 1'b1;
            r.txd    <= LINE_IDLE;
            r.rx_s1  <= LINE_IDLE;
            r.rx_s2  <= LINE_IDLE;
            r.rx_q   <= LINE_IDLE;
            r.ck_s1  <= LINE_IDLE;
            r.ck_s2  <= LINE_IDLE;
            r.ck_q   <= LINE_IDLE;
        end
        else
            r <= next_r;
    end

    assign TXD_OUT                = r.txd;
    assign HANDSHAKE_OUT_LINE_OUT = r.hs;
    assign RAM_WE_OUT             = r.ram_we;
    assign RAM_ADDR_OUT           = r.ram_addr;
    assign RAM_DATA_OUT           = r.ram_data;
    assign JUMP_OUT               = r.jump;
    assign JUMP_ADDR_OUT          = r.hdr[47:16];
    assign ABORT_OUT              = r.abort;
endmodule
`default_nettype wire

/* File: serial_boot_ram_loader_monitor.sv */
// checker for the serial boot ram transfer engine
`timescale 1ns/1ps
`default_nettype none
module serial_boot_ram_loader_monitor (
    // clock and reset
    input wire logic        SYS_CLK_IN,
    input wire logic        RSTN_IN,
    // watched pins
    input wire logic        TXD_OUT,
    input wire logic        RAM_READY_IN,
    input wire logic        RAM_WE_OUT,
    input wire logic [31:0] RAM_ADDR_OUT,
    input wire logic [7:0]  RAM_DATA_OUT,
    input wire logic        JUMP_OUT,
    input wire logic [31:0] JUMP_ADDR_OUT,
    input wire logic        ABORT_OUT
);
    logic        done_q;    // a write finished last cycle
    logic        seen_wr;   // some write finished this session
    logic [31:0] last_addr; // address of the latest finished write

    // track finished writes so address steps can be judged
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            done_q    <= 1'b0;
            seen_wr   <= 1'b0;
            last_addr <= 32'h0;
        end
        else
        begin
            done_q <= RAM_WE_OUT && RAM_READY_IN;
            if (RAM_WE_OUT && RAM_READY_IN)
            begin
                seen_wr   <= 1'b1;
                last_addr <= RAM_ADDR_OUT;
            end
        end
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    // a fresh write request, not one still stalled
    sequence s_new_wr;
        RAM_WE_OUT && (!$past(RAM_WE_OUT) || done_q);
    endsequence
    // a request the ram is refusing this cycle
    sequence s_stall;
        RAM_WE_OUT && !RAM_READY_IN;
    endsequence

    chk_stall_hold: assert property (s_stall |=>
        RAM_WE_OUT && $stable(RAM_ADDR_OUT) && $stable(RAM_DATA_OUT))
        else $error("ram write changed while stalled");
    chk_addr_step: assert property (s_new_wr ##0 seen_wr |->
        RAM_ADDR_OUT == last_addr + 32'h1)
        else $error("ram address did not step by one");
    chk_first_addr: assert property (s_new_wr ##0 !seen_wr |->
        RAM_ADDR_OUT == JUMP_ADDR_OUT)
        else $error("first write not at start address");
    chk_jaddr_stable: assert property (RAM_WE_OUT |=>
        $stable(JUMP_ADDR_OUT))
        else $error("start address moved during payload");
    chk_jump_pulse: assert property (JUMP_OUT |=> !JUMP_OUT)
        else $error("jump longer than one cycle");
    chk_jump_clean: assert property (JUMP_OUT |->
        !RAM_WE_OUT && !ABORT_OUT)
        else $error("jump with write pending or after abort");
    chk_abort_sticky: assert property (ABORT_OUT |=> ABORT_OUT)
        else $error("abort dropped before reset");
    chk_abort_quiet: assert property (ABORT_OUT |->
        TXD_OUT && !RAM_WE_OUT)
        else $error("activity after abort");
endmodule
bind serial_boot_ram_loader serial_boot_ram_loader_monitor mon (
    .SYS_CLK_IN, .RSTN_IN, .TXD_OUT, .RAM_READY_IN, .RAM_WE_OUT,
    .RAM_ADDR_OUT, .RAM_DATA_OUT, .JUMP_OUT, .JUMP_ADDR_OUT, .ABORT_OUT);
`default_nettype wire

/* File: host_link_model.sv */
// uart and clocked serial side of the programming controller
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
    parameter int P = 8              // bit period in system clocks
) (
    // timing reference
    input  wire logic clk_in,
    // link pins
    input  wire logic txd_in,
    output logic      rxd_out,
    output logic      sclk_out
);
    // the shift clock idles high
    initial
    begin
        rxd_out  = 1'b1;
        sclk_out = 1'b1;
    end

    // one 8n1 frame, lsb first, full stop bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd_out = f[i];
            repeat (P) @(negedge clk_in);
        end
    endtask

    // clocked byte each way, lsb first
    task automatic xfer(input logic [7:0] b, int h, output logic [7:0] a);
        for (int i = 0; i < 8; i++)
        begin
            {sclk_out, rxd_out} = {1'b0, b[i]};
            repeat (h) @(negedge clk_in);
            {sclk_out, a[i]} = {1'b1, txd_in};
            repeat (h) @(negedge clk_in);
        end
    endtask

    // wait a bounded time for an answer frame, sample mid-bit
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        b  = 8'h00;
        ok = 1'b0;
        n  = 0;
        while (txd_in !== 1'b0 && n < 30 * P)
        begin
            @(negedge clk_in);
            n++;
        end
        if (txd_in === 1'b0)
        begin
            repeat (P / 2) @(negedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
                repeat (P) @(negedge clk_in);
                b[i] = txd_in;
            end
            repeat (P) @(negedge clk_in);
            ok = (txd_in === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the serial boot ram transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    import serial_boot_pkg::*;
    logic        clk, rstn, rxd, sclk, txd, hs, rdy, we, jump, abort, ok;
    logic [95:0] pwd;                      // stored password
    logic [31:0] waddr, jaddr, exp_addr, start, jump_seen;
    logic [15:0] len;                      // payload length
    logic [7:0]  wdata, got;
    logic [7:0]  q [$];                    // bytes of one block
    logic [7:0]  pay [$];                  // payload not yet written
    int          err_total = 0, n_tests = 0, seed = 32'hd911;
    int          n_wr = 0, n_jump = 0;

    serial_boot_ram_loader uut (.SYS_CLK_IN(clk), .RSTN_IN(rstn),
        .RXD_IN(rxd), .SERIAL_SHIFT_CLOCK_IN(sclk), .TXD_OUT(txd),
        .HANDSHAKE_OUT_LINE_OUT(hs), .PASSWORD_IN(pwd),
        .RAM_READY_IN(rdy), .RAM_WE_OUT(we), .RAM_ADDR_OUT(waddr),
        .RAM_DATA_OUT(wdata), .JUMP_OUT(jump), .JUMP_ADDR_OUT(jaddr),
        .ABORT_OUT(abort));
    host_link_model #(.P(8)) host (.clk_in(clk), .txd_in(txd),
        .rxd_out(rxd), .sclk_out(sclk));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // send a byte and expect one answer frame
    task automatic xchg(input logic [7:0] b, input logic [7:0] exp);
        logic [7:0] a;
        logic       v;
        fork
            host.send(b);
            host.recv(a, v);
        join
        check({23'h0, v, a}, {23'h0, 1'b1, exp});
    endtask

    // bytes then their checksum, optionally spoilt by flip
    task automatic block(input logic [7:0] d [$], input logic [7:0] flip,
                         input logic [7:0] exp);
        logic [7:0] s;
        s = 8'h00;
        foreach (d[i])
        begin
            host.send(d[i]);
            s = s + d[i];
        end
        xchg((8'h00 - s) ^ flip, exp);
    endtask

    // ram stalls at random, three cycles in four ready
    always @(negedge clk)
        rdy = ($random(seed) & 32'h3) != 0;

    // score each finished write against the payload
    always @(posedge clk)
        if (we && rdy)
        begin
            n_wr++;
            check(waddr, exp_addr);
            if (pay.size() > 0)
                check({24'h0, wdata}, {24'h0, pay.pop_front()});
            exp_addr = exp_addr + 32'h1;
        end

    always @(posedge clk)
        if (jump)
        begin
            n_jump++;
            jump_seen = jaddr;
        end

    initial
    begin
        rstn = 1'b0;
        rdy  = 1'b0;
        pwd  = {$random(seed), $random(seed), $random(seed)};
        repeat (10) @(negedge clk);
        check({31'h0, txd}, 32'h1);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check({31'h0, hs}, 32'h1);
        xchg(MODE_UART_CODE, MODE_UART_CODE);
        xchg(8'h20, ANS_NAK);
        xchg(CMD_RAM_LOAD, CMD_RAM_LOAD);
        for (int k = 0; k < PWD_BYTES; k++)
            q.push_back(pwd[8*k +: 8]);
        block(q, 8'h01, ANS_NAK);
        xchg(CMD_RAM_LOAD, CMD_RAM_LOAD);
        q[11] = ~q[11];
        block(q, 8'h00, ANS_NAK);
        q[11] = ~q[11];
        xchg(CMD_RAM_LOAD, CMD_RAM_LOAD);
        block(q, 8'h00, CMD_RAM_LOAD);
        start = RAM_LOAD_BASE + {24'h0, 8'($random(seed))};
        len = 16'h1 + {12'h0, 4'($random(seed))};
        exp_addr = start;
        q = {start[31:24], start[23:16], start[15:8], start[7:0],
             len[15:8], len[7:0]};
        block(q, 8'h00, CMD_RAM_LOAD);
        q = {};
        for (int k = 0; k < len; k++)
            q.push_back(8'($random(seed)));
        pay = q;
        block(q, 8'h00, CMD_RAM_LOAD);
        for (int k = 0; k < 400 && n_jump == 0; k++)
            @(negedge clk);
        check(32'(n_wr), {16'h0, len});
        check(32'(n_jump), 32'h1);
        check(jump_seen, start);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        fork
            host.send(8'h0a);
            host.recv(got, ok);
        join
        check({31'h0, ok}, 32'h0);
        check({31'h0, abort}, 32'h1);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        host.xfer(MODE_CLKD_CODE, 128, got);
        host.xfer(8'hff, 128, got);
        check({24'h0, got}, {24'h0, MODE_CLKD_CODE});
        end_of_test();
    end

    // cut a hang short
    initial
    begin
        repeat (30000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
